/* File: uar_pkg.sv */
// uar_pkg: register map, field positions, reset values and timing constants
// assumes a 20 MHz core clock and a byte-wide register port
package uar_pkg;
  localparam logic [11:0] CTRL0_OFF  = 12'h420;
  localparam logic [11:0] CTRL1_OFF  = 12'h424;
  localparam logic [11:0] MATCH0_OFF = 12'h428;
  localparam logic [11:0] MASK0_OFF  = 12'h429;
  localparam logic [11:0] MATCH1_OFF = 12'h42c;
  localparam logic [11:0] MASK1_OFF  = 12'h42d;
  localparam logic [11:0] TXD0_OFF   = 12'h430;
  localparam logic [11:0] RXD0_OFF   = 12'h431;
  localparam logic [11:0] TXD1_OFF   = 12'h434;
  localparam logic [11:0] RXD1_OFF   = 12'h435;
  localparam logic [11:0] BAUD_OFF   = 12'h438;
  localparam logic [11:0] ISTAT_OFF  = 12'h43c;
  localparam logic [11:0] IMASK_OFF  = 12'h43d;
  // control register field positions
  localparam int CTL_MODEH = 7;
  localparam int CTL_MODEL = 6;
  localparam int CTL_MPCE  = 5;
  localparam int CTL_REN   = 4;
  localparam int CTL_TB8   = 3;
  localparam int CTL_RB8   = 2;
  localparam int CTL_TI    = 1;
  localparam int CTL_RI    = 0;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST  = 8'h0f;
  localparam logic [3:0] IRQ_RST   = 4'h0;
  // fixed bit rates as core clocks per bit
  localparam logic [7:0] DIV_MODE0 = 8'd16;
  localparam logic [7:0] DIV_MODE2 = 8'd32;
  typedef enum logic [1:0] {
    MODE_SHIFT, MODE_UART8, MODE_UART9F, MODE_UART9V
  } uar_mode_t;
endpackage : uar_pkg

/* File: uar_chan_if.sv */
// uar_chan_if: control/status bundle between top and one channel engine
// assumes one clock domain shared by both sides
`timescale 1ns/1ns
interface uar_chan_if;
  logic [7:0] ctrl;       // control register image
  logic [7:0] matchVal;
  logic [7:0] matchMask;
  logic [7:0] baudDiv;
  logic       txStart;    // pulse, txData valid
  logic [7:0] txData;
  logic       txDone;     // pulse when transmitter free again
  logic       rxDone;     // pulse when frame accepted
  logic [7:0] rxData;
  logic       rxNinth;
  logic       rxNinthWe;  // load rx_ninth_bit
  modport top  (output ctrl, matchVal, matchMask, baudDiv, txStart, txData,
                input txDone, rxDone, rxData, rxNinth, rxNinthWe);
  modport chan (input ctrl, matchVal, matchMask, baudDiv, txStart, txData,
                output txDone, rxDone, rxData, rxNinth, rxNinthWe);
endinterface : uar_chan_if

/* File: uar_channel.sv */
// uar_channel: one serial transmitter/receiver with address recognition
// assumes rxPin already synchronised by the caller
`timescale 1ns/1ns
module uar_channel
  import uar_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  uar_chan_if.chan  cif,
  input  wire logic rxPin,
  output logic      txPin
);
  typedef enum logic [1:0] {IDLE, START, BITS, STOP} uar_ph_t;
  uar_ph_t    txSt_q, txSt_d, rxSt_q, rxSt_d;
  logic [7:0] txCnt_q, txCnt_d, rxCnt_q, rxCnt_d;
  logic [3:0] txBit_q, txBit_d, rxBit_q, rxBit_d;
  logic [8:0] txSh_q, txSh_d, rxSh_q, rxSh_d;
  logic       txPin_d, txPin_q;
  logic [7:0] div, nbits, given, bcast, addr;
  logic       nine, mpce, hit, frameOk, stopBit;
  uar_mode_t  mode;
  assign mode  = uar_mode_t'({cif.ctrl[CTL_MODEH], cif.ctrl[CTL_MODEL]});
  assign mpce  = cif.ctrl[CTL_MPCE];
  assign nine  = mode == MODE_UART9F || mode == MODE_UART9V;
  assign div   = mode == MODE_SHIFT  ? DIV_MODE0 :
                 mode == MODE_UART9F ? DIV_MODE2 : cif.baudDiv;
  assign nbits = nine ? 8'd9 : 8'd8;
  // given and broadcast patterns; zero mask bits and zero broadcast bits are don't-care
  assign given = cif.matchVal & cif.matchMask;
  assign bcast = cif.matchVal | cif.matchMask;
  assign addr  = rxSh_q[7:0];
  assign hit   = ((addr & cif.matchMask) == given)
               || ((addr & bcast) == bcast);
  assign stopBit = rxPin;
  // ninth bit must be one for an address; compare only under mpce
  always_comb begin
    frameOk = 1'b1;
    if (mpce && nine)
      frameOk = rxSh_q[8] && hit;
    else if (mpce && mode == MODE_UART8)
      frameOk = stopBit;
  end
  // transmitter: start, 8 or 9 bits lsb first, stop
  always_comb begin
    txSt_d = txSt_q; txCnt_d = txCnt_q; txBit_d = txBit_q;
    txSh_d = txSh_q; txPin_d = txPin_q; cif.txDone = 1'b0;
    if (txSt_q != IDLE && txCnt_q != 8'd1) txCnt_d = txCnt_q - 8'd1;
    unique case (txSt_q)
      IDLE: if (cif.txStart) begin
        txSh_d = {cif.ctrl[CTL_TB8], cif.txData};
        txSt_d = START; txCnt_d = div; txPin_d = 1'b0;
      end
      START: if (txCnt_q == 8'd1) begin
        txSt_d = BITS; txCnt_d = div; txBit_d = 4'd0; txPin_d = txSh_q[0];
      end
      BITS: if (txCnt_q == 8'd1) begin
        txCnt_d = div;
        if ({4'h0, txBit_q} == nbits - 8'd1) begin
          txSt_d = STOP; txPin_d = 1'b1;
        end else begin
          txBit_d = txBit_q + 4'd1;
          txSh_d  = {1'b0, txSh_q[8:1]};
          txPin_d = txSh_q[1];
        end
      end
      STOP: if (txCnt_q == 8'd1) begin
        txSt_d = IDLE; cif.txDone = 1'b1;
      end
    endcase
  end
  // receiver: samples mid-bit; a start bit is only taken while reception enabled
  always_comb begin
    rxSt_d = rxSt_q; rxCnt_d = rxCnt_q; rxBit_d = rxBit_q; rxSh_d = rxSh_q;
    cif.rxDone = 1'b0; cif.rxNinthWe = 1'b0; cif.rxNinth = 1'b0;
    if (rxSt_q != IDLE && rxCnt_q != 8'd1) rxCnt_d = rxCnt_q - 8'd1;
    unique case (rxSt_q)
      IDLE: if (cif.ctrl[CTL_REN] && !rxPin) begin
        rxSt_d = START; rxCnt_d = {1'b0, div[7:1]};
      end
      START: if (rxCnt_q == 8'd1) begin
        // a glitch shorter than half a bit is dropped
        rxSt_d = rxPin ? IDLE : BITS; rxCnt_d = div; rxBit_d = 4'd0;
      end
      BITS: if (rxCnt_q == 8'd1) begin
        rxCnt_d = div;
        rxSh_d  = nine ? {rxPin, rxSh_q[8:1]} : {1'b0, rxPin, rxSh_q[7:1]};
        if ({4'h0, rxBit_q} == nbits - 8'd1) rxSt_d = STOP;
        else rxBit_d = rxBit_q + 4'd1;
      end
      STOP: if (rxCnt_q == 8'd1) begin
        rxSt_d = IDLE;
        if (frameOk) begin
          cif.rxDone = 1'b1;
          if (mode != MODE_SHIFT) begin
            cif.rxNinthWe = 1'b1;
            cif.rxNinth   = nine ? rxSh_q[8] : stopBit;
          end
        end
      end
    endcase
  end
  assign cif.rxData = rxSh_q[7:0];
  assign txPin      = txPin_q;
  // state registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txSt_q <= IDLE; txCnt_q <= 8'h00; txBit_q <= 4'h0; txSh_q <= 9'h000;
      txPin_q <= 1'b1; rxSt_q <= IDLE; rxCnt_q <= 8'h00; rxBit_q <= 4'h0;
      rxSh_q <= 9'h000;
    end else begin
      txSt_q <= txSt_d; txCnt_q <= txCnt_d; txBit_q <= txBit_d;
      txSh_q <= txSh_d; txPin_q <= txPin_d; rxSt_q <= rxSt_d;
      rxCnt_q <= rxCnt_d; rxBit_q <= rxBit_d; rxSh_q <= rxSh_d;
    end
  end
endmodule : uar_channel

/* File: uar_ctrl.sv */
// uar_ctrl: two serial channels with address recognition and register port
// assumes rxd pins are asynchronous; register port on the core clock
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
// Behaviour
// - broadcast pattern is match OR mask
// - zero bits of broadcast pattern ignored
// - match and mask registers reset to zero
// - all-zero registers accept any address
// - receive only while receive enable set
// - ninth bit or stop bit into rx_ninth_bit
// - tx done set by hardware, software clears
// - given pattern is match AND mask
// - nine-bit compare sets rx done on hit
// - address bytes carry ninth bit one
// - compare off: every character sets rx done
module uar_ctrl
  import uar_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  input  wire logic [1:0]  rxdPin,
  output logic      [1:0]  txdPin,
  output logic             irq
);
  import uar_pkg::*;
  uar_chan_if cif0 ();
  uar_chan_if cif1 ();
  logic [7:0] ctrl_q [2], ctrl_d [2];
  logic [7:0] match_q [2], match_d [2];
  logic [7:0] mask_q [2], mask_d [2];
  logic [7:0] rxBuf_q [2], rxBuf_d [2];
  logic [7:0] baud_q, baud_d;
  logic [3:0] istat_q, istat_d, imask_q, imask_d;
  logic [7:0] rdata_d, rdata_q;
  logic [1:0] sync1_q, sync2_q;
  logic [1:0] txDone, rxDone, rxNinthWe, rxNinth, txStart;
  logic [7:0] rxData [2];
  logic [7:0] txData_q, txData_d;

  // two-flop synchroniser for the serial inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
    end else begin
      sync1_q <= rxdPin;
      sync2_q <= sync1_q;
    end
  end

  // channel bundles
  assign cif0.ctrl      = ctrl_q[0];
  assign cif0.matchVal  = match_q[0];
  assign cif0.matchMask = mask_q[0];
  assign cif0.baudDiv   = baud_q;
  assign cif0.txStart   = txStart[0];
  assign cif0.txData    = txData_q;
  assign cif1.ctrl      = ctrl_q[1];
  assign cif1.matchVal  = match_q[1];
  assign cif1.matchMask = mask_q[1];
  assign cif1.baudDiv   = baud_q;
  assign cif1.txStart   = txStart[1];
  assign cif1.txData    = txData_q;
  assign txDone    = {cif1.txDone, cif0.txDone};
  assign rxDone    = {cif1.rxDone, cif0.rxDone};
  assign rxNinthWe = {cif1.rxNinthWe, cif0.rxNinthWe};
  assign rxNinth   = {cif1.rxNinth, cif0.rxNinth};
  assign rxData[0] = cif0.rxData;
  assign rxData[1] = cif1.rxData;

  // one engine per channel; mode decode inside follows the two mode bits
  uar_channel u_chan0 (
    .clk   (clk),
    .rst_n (rst_n),
    .cif   (cif0),
    .rxPin (sync2_q[0]),
    .txPin (txdPin[0])
  );
  uar_channel u_chan1 (
    .clk   (clk),
    .rst_n (rst_n),
    .cif   (cif1),
    .rxPin (sync2_q[1]),
    .txPin (txdPin[1])
  );

  // tx start is delayed one cycle so txData_q holds the written byte
  logic [1:0] txGo_q, txGo_d;
  assign txStart = txGo_q;

  // register writes, hardware flag updates; hardware sets beat clears
  always_comb begin
    logic [11:0] cOff;
    cOff = 12'h000;
    baud_d = baud_q; imask_d = imask_q; istat_d = istat_q;
    txData_d = txData_q; txGo_d = 2'b00;
    for (int c = 0; c < 2; c++) begin
      cOff = c == 0 ? 12'h000 : 12'h004;
      ctrl_d[c] = ctrl_q[c]; match_d[c] = match_q[c];
      mask_d[c] = mask_q[c]; rxBuf_d[c] = rxBuf_q[c];
      if (regWr) begin
        if (regAddr == CTRL0_OFF + cOff) ctrl_d[c] = regWdata;
        if (regAddr == MATCH0_OFF + cOff) match_d[c] = regWdata;
        if (regAddr == MASK0_OFF + cOff) mask_d[c] = regWdata;
        if (regAddr == TXD0_OFF + cOff) begin
          txData_d = regWdata;
          txGo_d[c] = 1'b1;
        end
      end
      if (rxNinthWe[c]) ctrl_d[c][CTL_RB8] = rxNinth[c];
      if (txDone[c]) ctrl_d[c][CTL_TI] = 1'b1;
      if (rxDone[c]) begin
        ctrl_d[c][CTL_RI] = 1'b1;
        rxBuf_d[c] = rxData[c];
      end
    end
    if (regWr && regAddr == BAUD_OFF) baud_d = regWdata;
    if (regWr && regAddr == IMASK_OFF) imask_d = regWdata[3:0];
    if (regWr && regAddr == ISTAT_OFF) istat_d = istat_q & ~regWdata[3:0];
    // status: rx0, tx0, rx1, tx1 events, sticky
    istat_d = istat_d | {txDone[1], rxDone[1], txDone[0], rxDone[0]};
  end

  // read data, registered: stands the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        CTRL0_OFF:  rdata_d = ctrl_q[0];
        CTRL1_OFF:  rdata_d = ctrl_q[1];
        MATCH0_OFF: rdata_d = match_q[0];
        MASK0_OFF:  rdata_d = mask_q[0];
        MATCH1_OFF: rdata_d = match_q[1];
        MASK1_OFF:  rdata_d = mask_q[1];
        RXD0_OFF:   rdata_d = rxBuf_q[0];
        RXD1_OFF:   rdata_d = rxBuf_q[1];
        BAUD_OFF:   rdata_d = baud_q;
        ISTAT_OFF:  rdata_d = {4'h0, istat_q};
        IMASK_OFF:  rdata_d = {4'h0, imask_q};
        default:    rdata_d = 8'h00;                 // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        ctrl_q[c]  <= CTRL_RST;
        match_q[c] <= MATCH_RST;
        mask_q[c]  <= MASK_RST;
        rxBuf_q[c] <= 8'h00;
      end
      baud_q <= BAUD_RST; istat_q <= IRQ_RST; imask_q <= IRQ_RST;
      rdata_q <= 8'h00; txData_q <= 8'h00; txGo_q <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        ctrl_q[c]  <= ctrl_d[c];
        match_q[c] <= match_d[c];
        mask_q[c]  <= mask_d[c];
        rxBuf_q[c] <= rxBuf_d[c];
      end
      baud_q <= baud_d; istat_q <= istat_d; imask_q <= imask_d;
      rdata_q <= rdata_d; txData_q <= txData_d; txGo_q <= txGo_d;
    end
  end

  assign regRdata = rdata_q;
  // level interrupt while any unmasked sticky bit stands
  assign irq = |(istat_q & imask_q);
endmodule : uar_ctrl

/* File: uar_chk.sv */
// uar_chk: port-level checks of the serial control block
// assumes binding into uar_ctrl; sees only its ports
`timescale 1ns/1ns
module uar_chk
  import uar_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdata,
  input wire logic [1:0]  rxdPin,
  input wire logic [1:0]  txdPin,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] shM_q;
  logic [7:0] shK_q;
  logic [8:0] idle_q;
  // shadows of match/mask 0; idle count saturates so a long idle gap is safe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shM_q  <= 8'h00;
      shK_q  <= 8'h00;
      idle_q <= 9'h000;
    end else begin
      if (regWr && regAddr == MATCH0_OFF) shM_q <= regWdata;
      if (regWr && regAddr == MASK0_OFF) shK_q <= regWdata;
      idle_q <= !txdPin[0] ? 9'h000 : idle_q + 9'(idle_q != 9'h1ff);
    end
  end
  property p_quiet; !$past(regRd) |-> regRdata == 8'h00; endproperty
  a_quiet: assert property (p_quiet) else $error("rdata not idle");
  property p_match;
    regRd && regAddr == MATCH0_OFF |=> regRdata == shM_q;
  endproperty
  a_match: assert property (p_match) else $error("match readback");
  property p_mask; regRd && regAddr == MASK0_OFF |=> regRdata == shK_q;
  endproperty
  a_mask: assert property (p_mask) else $error("mask readback");
  property p_unmap; regRd && regAddr == 12'h7fe |=> regRdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_txgo;
    regWr && regAddr == TXD0_OFF && idle_q == 9'h1ff |-> ##2 !txdPin[0];
  endproperty
  a_txgo: assert property (p_txgo) else $error("frame did not start");
  property p_irqoff;
    regWr && regAddr == IMASK_OFF && regWdata == 8'h00 |-> ##[1:3] !irq;
  endproperty
  a_irqoff: assert property (p_irqoff) else $error("irq not masked");
  property p_txrst; $past(rst_n) == 1'b0 |-> txdPin == 2'b11; endproperty
  a_txrst: assert property (p_txrst) else $error("txd not idle");
  property p_start; $fell(txdPin[0]) |-> (!txdPin[0]) [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit short");
endmodule : uar_chk
bind uar_ctrl uar_chk u_chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .rxdPin(rxdPin), .txdPin(txdPin), .irq(irq));

/* File: uar_node.sv */
// uar_node: remote serial node on one channel's line pair
// assumes idle-high lines and bit times in core clocks set by the bench
`timescale 1ns/1ns
module uar_node (
  input  wire logic       clk,
  input  wire logic       txd,
  input  wire logic [7:0] rxDiv,
  input  wire logic       rxNine,
  output logic            rxd
);
  logic [8:0] got;
  int         gotCnt = 0;
  initial rxd = 1'b1;
  // one frame lsb first; ninth high marks an address byte
  task automatic sendFrame(input logic [7:0] d, input logic n9,
                           input logic nine, input int div);
    logic [10:0] f;
    f = {1'b1, n9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (nine || i != 9) begin
        rxd <= f[i];
        repeat (div) @(posedge clk);
      end
    end
  endtask
  // decode block frames, sampled mid bit; no framing check kept
  always begin
    @(negedge txd);
    repeat (rxDiv / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (rxDiv) @(posedge clk);
      if (i < 8 || rxNine) got[i] = txd;
    end
    gotCnt++;
  end
endmodule : uar_node

/* File: tb.sv */
// tb: self-checking bench for the two-channel serial control block
// assumes uar_pkg constants and the remote node model uar_node
`timescale 1ns/1ns
module tb;
  import uar_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0]  regWdata = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [7:0]  regRdata;
  wire  [1:0]  rxdPin;
  logic [1:0]  txdPin;
  logic        irq;
  logic [7:0]  rxDiv = 8'd20;
  logic        rxNine = 1'b1;
  logic [7:0]  rd, a, c, d;
  logic [8:0]  ex;
  logic [8:0]  txQ [$];    // model: frames still owed on the line
  logic [7:0]  tbl [6] = '{8'he5, 8'he6, 8'hff, 8'hfa, 8'he4, 8'he5};
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  int          cnt;
  int          seed = 32'hf7061743;
  always #25 clk = ~clk;
  uar_ctrl uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .rxdPin(rxdPin), .txdPin(txdPin), .irq(irq));
  uar_node n0 (.clk(clk), .txd(txdPin[0]), .rxDiv(rxDiv), .rxNine(rxNine),
    .rxd(rxdPin[0]));
  uar_node n1 (.clk(clk), .txd(txdPin[1]), .rxDiv(rxDiv), .rxNine(rxNine),
    .rxd(rxdPin[1]));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // a gap cycle after each strobe keeps one assignment per step
  task automatic wr(input logic [11:0] ad, input logic [7:0] v);
    regAddr  <= ad;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rdr(input logic [11:0] ad);
    regAddr <= ad;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rd = regRdata;
    @(posedge clk);
  endtask : rdr
  // reference: given or broadcast hit on an address byte
  function automatic logic hit(input logic [7:0] x, m, k, input logic n9);
    hit = n9 && ((x & k) == (m & k) || (x & (m | k)) == (m | k));
  endfunction : hit
  function automatic int divOf(input logic [7:0] x);
    divOf = x[7:6] == 2'b00 ? 16 : (x[7:6] == 2'b10 ? 32 : 20);
  endfunction : divOf
  task automatic rxOne(input int ch, input logic [7:0] ctl, v,
                       input logic n9, nb, exp);
    wr(ch ? CTRL1_OFF : CTRL0_OFF, ctl);
    if (ch) n1.sendFrame(v, n9, ctl[7], divOf(ctl));
    else n0.sendFrame(v, n9, ctl[7], divOf(ctl));
    repeat (4) @(posedge clk);
    rdr(ch ? CTRL1_OFF : CTRL0_OFF);
    chk(rd[CTL_RI], exp);
    if (exp && ctl[7:6] != 2'b00) chk(rd[CTL_RB8], nb);
    if (exp) rdr(ch ? RXD1_OFF : RXD0_OFF);
    if (exp) chk(rd, v);
  endtask : rxOne
  // hang guard: a whole run needs well under this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (tbl[i]) begin
      rdr(i < 4 ? CTRL0_OFF + 12'(4 * i) : 12'h7fe);
      chk(rd, 8'h00);
    end
    rdr(MASK0_OFF);
    chk(rd, MASK_RST);
    rdr(MASK1_OFF);
    chk(rd, MASK_RST);
    rdr(BAUD_OFF);
    chk(rd, BAUD_RST);
    wr(BAUD_OFF, 8'd20);
    // cleared match registers take any address, both channels
    for (int ch = 0; ch < 2; ch++) rxOne(ch, 8'hf0, 8'($random(seed)), 1, 1, 1);
    wr(MATCH0_OFF, 8'he0);
    wr(MASK0_OFF, 8'hfa);
    rdr(MATCH0_OFF);
    chk(rd, 8'he0);
    rdr(MASK0_OFF);
    chk(rd, 8'hfa);
    for (int i = 0; i < 10; i++) begin
      a = i < 6 ? tbl[i] : 8'($random(seed));
      rxOne(0, 8'hf0, a, i != 5, 1, hit(a, 8'he0, 8'hfa, i != 5));
    end
    rxOne(0, 8'hd0, 8'($random(seed)), 0, 0, 1);
    rxOne(0, 8'hc0, 8'h5a, 1, 1, 0);
    rxOne(0, 8'h50, 8'h3c, 0, 1, 1);
    rxOne(0, 8'h90, 8'hc3, 1, 1, 1);
    rxOne(0, 8'h10, 8'h81, 0, 0, 1);
    // transmit in every mode with the ninth bit set
    for (int mo = 0; mo < 4; mo++) begin
      c = {mo[1:0], 6'h08};
      wr(CTRL0_OFF, c);
      rxDiv  <= 8'(divOf(c));
      rxNine <= c[7];
      cnt = n0.gotCnt;
      d = 8'($random(seed));
      txQ.push_back({1'b1, d});
      wr(TXD0_OFF, d);
      for (int j = 0; j < 800 && n0.gotCnt == cnt; j++) @(posedge clk);
      ex = txQ.pop_front();
      chk(n0.got[7:0], ex[7:0]);
      if (c[7]) chk(n0.got[8], ex[8]);
      repeat (80) @(posedge clk);
      rdr(CTRL0_OFF);
      chk(rd[CTL_TI], 1'b1);
    end
    // channel 1 transmit, nine-bit variable rate, node still set for it
    wr(CTRL1_OFF, 8'hc8);
    cnt = n1.gotCnt;
    d = 8'($random(seed));
    txQ.push_back({1'b1, d});
    wr(TXD1_OFF, d);
    for (int j = 0; j < 800 && n1.gotCnt == cnt; j++) @(posedge clk);
    ex = txQ.pop_front();
    chk(n1.got, ex);
    repeat (80) @(posedge clk);
    rdr(ISTAT_OFF);
    chk(rd[3], 1'b1);
    repeat (200) @(posedge clk);
    rdr(CTRL0_OFF);
    chk(rd[CTL_TI], 1'b1);
    chk(irq, 1'b0);
    wr(IMASK_OFF, 8'h02);
    chk(irq, 1'b1);
    wr(IMASK_OFF, 8'h00);
    chk(irq, 1'b0);
    wr(IMASK_OFF, 8'h02);
    wr(ISTAT_OFF, 8'h02);
    chk(irq, 1'b0);
    end_of_test();
  end
endmodule : tb
